// ==== core/pad_drive.sv ====
// per-pin pad control from effective direction and config bits
// purely combinational; caller registers the results
`timescale 1ns/1ps
module pad_drive #(
	parameter int   WIDTH      = 8,
	parameter logic PULL_ON_OD = 1'b0
) (
	input  wire logic [WIDTH-1:0] dir,
	input  wire logic [WIDTH-1:0] data,
	input  wire logic [WIDTH-1:0] reduce,
	input  wire logic [WIDTH-1:0] pull_en,
	input  wire logic [WIDTH-1:0] pull_pol,
	input  wire logic [WIDTH-1:0] open_drain,
	input  wire logic [WIDTH-1:0] od_force,
	output logic      [WIDTH-1:0] next_oe,
	output logic      [WIDTH-1:0] next_reduced,
	output logic      [WIDTH-1:0] next_pull_en,
	output logic      [WIDTH-1:0] next_pull_down,
	output logic      [WIDTH-1:0] next_od
);
	always_comb begin
		next_od        = od_force | (open_drain & dir);
		next_oe        = dir & (~next_od | ~data);
		next_reduced   = reduce & dir;
		next_pull_en   = pull_en & (~dir | (next_od & {WIDTH{PULL_ON_OD}}));
		next_pull_down = pull_pol & pull_en & ~dir;
	end
endmodule : pad_drive

// ==== core/pin_sync.sv ====
// two-flop synchroniser for pad levels
// assumes inputs come from outside the aclk domain
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : pin_sync

// ==== core/port_pin_config.sv ====
// pin configuration and muxing for two general-purpose ports
// assumes AXI4-Lite master on aclk; peripherals on aclk; pads asynchronous
`timescale 1ns/1ps
module port_pin_config
	import port_pins_pkg::*;
(
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	input  wire logic [port_pins_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                            s_axi_awvalid,
	output logic                                 s_axi_awready,
	input  wire logic [31:0]                     s_axi_wdata,
	input  wire logic [3:0]                      s_axi_wstrb,
	input  wire logic                            s_axi_wvalid,
	output logic                                 s_axi_wready,
	output logic [1:0]                           s_axi_bresp,
	output logic                                 s_axi_bvalid,
	input  wire logic                            s_axi_bready,
	input  wire logic [port_pins_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                            s_axi_arvalid,
	output logic                                 s_axi_arready,
	output logic [31:0]                          s_axi_rdata,
	output logic [1:0]                           s_axi_rresp,
	output logic                                 s_axi_rvalid,
	input  wire logic                            s_axi_rready,
	input  wire logic [port_pins_pkg::P_PINS-1:0] port_p_dir,
	input  wire logic                            twi_enable,
	input  wire logic [1:0]                      pwm_twi_ch_enable,
	input  wire logic                            spi_enable,
	input  wire logic [3:0]                      spi_out,
	input  wire logic [3:0]                      spi_oe,
	input  wire logic                            sci_tx_enable,
	input  wire logic                            sci_tx_data,
	input  wire logic                            sci_rx_enable,
	input  wire logic [port_pins_pkg::S_PINS-1:0] pad_s_in,
	output logic [port_pins_pkg::P_PINS-1:0]     pad_p_reduced,
	output logic [port_pins_pkg::P_PINS-1:0]     pad_p_pull_en,
	output logic [port_pins_pkg::P_PINS-1:0]     pad_p_pull_down,
	output logic [port_pins_pkg::P_PINS-1:0]     pad_p_open_drain,
	output logic [port_pins_pkg::S_PINS-1:0]     pad_s_out,
	output logic [port_pins_pkg::S_PINS-1:0]     pad_s_oe,
	output logic [port_pins_pkg::S_PINS-1:0]     pad_s_reduced,
	output logic [port_pins_pkg::S_PINS-1:0]     pad_s_pull_en,
	output logic [port_pins_pkg::S_PINS-1:0]     pad_s_pull_down,
	output logic [port_pins_pkg::S_PINS-1:0]     pad_s_open_drain,
	output logic [3:0]                           spi_in,
	output logic                                 sci_rx_data
);
	import port_pins_pkg::*;

	logic [7:0]        port_p_drive_reduce;
	logic [7:0]        port_p_pull_enable;
	logic [7:0]        port_p_pull_polarity;
	logic [7:0]        port_p_open_drain;
	logic [7:0]        port_s_data;
	logic [7:0]        port_s_direction;
	logic [7:0]        port_s_drive_reduce;
	logic [7:0]        port_s_pull_enable;
	logic [7:0]        port_s_pull_polarity;
	logic [7:0]        port_s_open_drain;
	logic [S_PINS-1:0] port_s_pin_level;

	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              aw_take;
	logic              w_take;
	logic              ar_take;
	logic              do_write;

	// byte-lane write of an 8-bit register, unimplemented bits stay zero
	function automatic logic [7:0] lane_write(
		input logic [7:0] old,
		input logic [7:0] data,
		input logic       strb,
		input logic [7:0] mask
	);
		lane_write = strb ? (data & mask) : old;
	endfunction : lane_write

	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		logic [7:0] a;
		a = 8'(addr);
		is_mapped = (a[1:0] == 2'b00) && (a <= OFF_S_OPEN_DRAIN);
	endfunction : is_mapped

	function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] addr);
		logic [7:0] a;
		a = 8'(addr);
		if (a == OFF_P_DRIVE_REDUCE) begin
			read_mux = port_p_drive_reduce;
		end else if (a == OFF_P_PULL_ENABLE) begin
			read_mux = port_p_pull_enable;
		end else if (a == OFF_P_PULL_POLARITY) begin
			read_mux = port_p_pull_polarity;
		end else if (a == OFF_P_OPEN_DRAIN) begin
			read_mux = port_p_open_drain;
		end else if (a == OFF_S_DATA) begin
			read_mux = ((port_s_data & port_s_direction) |
				(port_s_pin_level & ~port_s_direction)) & S_MASK;
		end else if (a == OFF_S_PIN_LEVEL) begin
			read_mux = port_s_pin_level;
		end else if (a == OFF_S_DIRECTION) begin
			read_mux = port_s_direction;
		end else if (a == OFF_S_DRIVE_REDUCE) begin
			read_mux = port_s_drive_reduce;
		end else if (a == OFF_S_PULL_ENABLE) begin
			read_mux = port_s_pull_enable;
		end else if (a == OFF_S_PULL_POLARITY) begin
			read_mux = port_s_pull_polarity;
		end else if (a == OFF_S_OPEN_DRAIN) begin
			read_mux = port_s_open_drain;
		end else begin
			read_mux = 8'h00;
		end
	endfunction : read_mux

	pin_sync #(
		.WIDTH(S_PINS)
	) u_s_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.async_in(pad_s_in),
		.sync_out(port_s_pin_level)
	);

	assign spi_in      = port_s_pin_level[S_PINS-1:S_SPI_LO];
	assign sci_rx_data = port_s_pin_level[S_RX_PIN];

	assign aw_take  = s_axi_awvalid && s_axi_awready;
	assign w_take   = s_axi_wvalid && s_axi_wready;
	assign ar_take  = s_axi_arvalid && s_axi_arready;
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// write address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			aw_held       <= 1'b0;
			aw_addr       <= '0;
		end else begin
			if (aw_take) begin
				s_axi_awready <= 1'b0;
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end else if (!aw_held && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	// write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b0;
			w_held       <= 1'b0;
			w_data       <= '0;
			w_strb       <= '0;
		end else begin
			if (w_take) begin
				s_axi_wready <= 1'b0;
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end else if (!w_held && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register file
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_p_drive_reduce  <= REG_RESET;
			port_p_pull_enable   <= REG_RESET;
			port_p_pull_polarity <= REG_RESET;
			port_p_open_drain    <= REG_RESET;
			port_s_data          <= REG_RESET;
			port_s_direction     <= REG_RESET;
			port_s_drive_reduce  <= REG_RESET;
			port_s_pull_enable   <= REG_RESET;
			port_s_pull_polarity <= REG_RESET;
			port_s_open_drain    <= REG_RESET;
		end else if (do_write) begin
			if (8'(aw_addr) == OFF_P_DRIVE_REDUCE) begin
				port_p_drive_reduce <= lane_write(port_p_drive_reduce,
					w_data[7:0], w_strb[0], P_MASK);
			end else if (8'(aw_addr) == OFF_P_PULL_ENABLE) begin
				port_p_pull_enable <= lane_write(port_p_pull_enable,
					w_data[7:0], w_strb[0], P_MASK);
			end else if (8'(aw_addr) == OFF_P_PULL_POLARITY) begin
				port_p_pull_polarity <= lane_write(port_p_pull_polarity,
					w_data[7:0], w_strb[0], P_MASK);
			end else if (8'(aw_addr) == OFF_P_OPEN_DRAIN) begin
				port_p_open_drain <= lane_write(port_p_open_drain,
					w_data[7:0], w_strb[0], P_OD_MASK);
			end else if (8'(aw_addr) == OFF_S_DATA) begin
				port_s_data <= lane_write(port_s_data,
					w_data[7:0], w_strb[0], S_MASK);
			end else if (8'(aw_addr) == OFF_S_DIRECTION) begin
				port_s_direction <= lane_write(port_s_direction,
					w_data[7:0], w_strb[0], S_MASK);
			end else if (8'(aw_addr) == OFF_S_DRIVE_REDUCE) begin
				port_s_drive_reduce <= lane_write(port_s_drive_reduce,
					w_data[7:0], w_strb[0], S_MASK);
			end else if (8'(aw_addr) == OFF_S_PULL_ENABLE) begin
				port_s_pull_enable <= lane_write(port_s_pull_enable,
					w_data[7:0], w_strb[0], S_MASK);
			end else if (8'(aw_addr) == OFF_S_PULL_POLARITY) begin
				port_s_pull_polarity <= lane_write(port_s_pull_polarity,
					w_data[7:0], w_strb[0], S_MASK);
			end else if (8'(aw_addr) == OFF_S_OPEN_DRAIN) begin
				port_s_open_drain <= lane_write(port_s_open_drain,
					w_data[7:0], w_strb[0], S_MASK);
			end
		end
	end

	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h00_0000, read_mux(s_axi_araddr)};
			s_axi_rresp   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// second port ownership and first port two-wire open drain force
	logic [S_PINS-1:0] s_dir;
	logic [S_PINS-1:0] s_val;
	logic [P_PINS-1:0] p_force;

	always_comb begin
		s_dir = port_s_direction[S_PINS-1:0];
		s_val = port_s_data[S_PINS-1:0];
		if (spi_enable) begin
			s_dir[S_PINS-1:S_SPI_LO] = spi_oe;
			s_val[S_PINS-1:S_SPI_LO] = spi_out;
		end
		if (sci_tx_enable) begin
			s_dir[S_TX_PIN] = 1'b1;
			s_val[S_TX_PIN] = sci_tx_data;
		end
		if (sci_rx_enable) begin
			s_dir[S_RX_PIN] = 1'b0;
		end
		p_force = '0;
		p_force[P_TWI_LO+1] = twi_enable && !pwm_twi_ch_enable[1];
		p_force[P_TWI_LO]   = twi_enable && !pwm_twi_ch_enable[0];
	end

	logic [P_PINS-1:0] next_p_reduced;
	logic [P_PINS-1:0] next_p_pull_en;
	logic [P_PINS-1:0] next_p_pull_down;
	logic [P_PINS-1:0] next_p_od;
	logic [S_PINS-1:0] next_s_oe;
	logic [S_PINS-1:0] next_s_reduced;
	logic [S_PINS-1:0] next_s_pull_en;
	logic [S_PINS-1:0] next_s_pull_down;
	logic [S_PINS-1:0] next_s_od;

	pad_drive #(
		.WIDTH     (P_PINS),
		.PULL_ON_OD(1'b0)
	) u_p_pads (
		.dir           (port_p_dir),
		.data          ('0),
		.reduce        (port_p_drive_reduce[P_PINS-1:0]),
		.pull_en       (port_p_pull_enable[P_PINS-1:0]),
		.pull_pol      (port_p_pull_polarity[P_PINS-1:0]),
		.open_drain    (port_p_open_drain[P_PINS-1:0]),
		.od_force      (p_force),
		.next_oe       (),
		.next_reduced  (next_p_reduced),
		.next_pull_en  (next_p_pull_en),
		.next_pull_down(next_p_pull_down),
		.next_od       (next_p_od)
	);

	pad_drive #(
		.WIDTH     (S_PINS),
		.PULL_ON_OD(1'b1)
	) u_s_pads (
		.dir           (s_dir),
		.data          (s_val),
		.reduce        (port_s_drive_reduce[S_PINS-1:0]),
		.pull_en       (port_s_pull_enable[S_PINS-1:0]),
		.pull_pol      (port_s_pull_polarity[S_PINS-1:0]),
		.open_drain    (port_s_open_drain[S_PINS-1:0]),
		.od_force      ('0),
		.next_oe       (next_s_oe),
		.next_reduced  (next_s_reduced),
		.next_pull_en  (next_s_pull_en),
		.next_pull_down(next_s_pull_down),
		.next_od       (next_s_od)
	);

	// registered pad controls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_p_reduced    <= '0;
			pad_p_pull_en    <= '0;
			pad_p_pull_down  <= '0;
			pad_p_open_drain <= '0;
		end else begin
			pad_p_reduced    <= next_p_reduced;
			pad_p_pull_en    <= next_p_pull_en;
			pad_p_pull_down  <= next_p_pull_down;
			pad_p_open_drain <= next_p_od;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_s_out        <= '0;
			pad_s_oe         <= '0;
			pad_s_reduced    <= '0;
			pad_s_pull_en    <= '0;
			pad_s_pull_down  <= '0;
			pad_s_open_drain <= '0;
		end else begin
			pad_s_out        <= s_val;
			pad_s_oe         <= next_s_oe;
			pad_s_reduced    <= next_s_reduced;
			pad_s_pull_en    <= next_s_pull_en;
			pad_s_pull_down  <= next_s_pull_down;
			pad_s_open_drain <= next_s_od;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_reset_floats: assert property (disable iff (1'b0)
		!aresetn |=> (pad_s_oe == '0) && (pad_s_pull_en == '0))
		else $error("second port not floating after reset");
	chk_reduce_output: assert property (
		port_p_dir[0] |=> pad_p_reduced[0] == $past(port_p_drive_reduce[0]))
		else $error("reduced drive not passed to output pad");
	chk_reduce_input: assert property (
		!s_dir[5] |=> !pad_s_reduced[5])
		else $error("reduced drive active on input");
	chk_pull_output: assert property (
		port_p_dir[1] |=> !pad_p_pull_en[1] && !pad_p_pull_down[1])
		else $error("first port pull active on output");
	chk_od_mask: assert property (
		!pad_p_open_drain[3] && !pad_p_open_drain[1])
		else $error("unimplemented open drain bit set");
	chk_twi_force: assert property (
		twi_enable && !pwm_twi_ch_enable[0] |=> pad_p_open_drain[4])
		else $error("two-wire pin not forced open drain");
	chk_spi_owns: assert property (
		spi_enable && port_s_open_drain[7:4] == 4'h0
		|=> pad_s_oe[7:4] == $past(spi_oe) && pad_s_out[7:4] == $past(spi_out))
		else $error("SPI does not own upper pins");
	chk_tx_owns: assert property (
		sci_tx_enable && !port_s_open_drain[1]
		|=> pad_s_oe[1] && pad_s_out[1] == $past(sci_tx_data))
		else $error("transmit pin not driven");
	chk_rx_input: assert property (
		sci_rx_enable |=> !pad_s_oe[0])
		else $error("receive pin driven");
	chk_gpio_dir: assert property (
		!spi_enable && !port_s_open_drain[6]
		|=> pad_s_oe[6] == $past(port_s_direction[6]))
		else $error("direction bit not steering pin");
	chk_od_pull: assert property (
		s_dir[7] && port_s_open_drain[7] && port_s_pull_enable[7]
		|=> pad_s_pull_en[7] && !pad_s_pull_down[7])
		else $error("pull missing on open drain output");

	cov_write: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
	cov_read: cover property (ar_take ##[1:4] s_axi_rvalid && s_axi_rready);
	cov_spi: cover property (spi_enable ##1 pad_s_oe[6]);
	cov_twi: cover property (twi_enable ##1 pad_p_open_drain[5]);
endmodule : port_pin_config

// ==== include/port_pins_pkg.sv ====
// constants for the two-port pin configuration block
// assumes a 32-bit AXI4-Lite register bus, one register per aligned word
package port_pins_pkg;
	localparam int ADDR_W = 8;
	localparam int P_PINS = 6;
	localparam int S_PINS = 8;

	// register byte offsets
	localparam logic [7:0] OFF_P_DRIVE_REDUCE  = 8'h00;
	localparam logic [7:0] OFF_P_PULL_ENABLE   = 8'h04;
	localparam logic [7:0] OFF_P_PULL_POLARITY = 8'h08;
	localparam logic [7:0] OFF_P_OPEN_DRAIN    = 8'h0C;
	localparam logic [7:0] OFF_S_DATA          = 8'h10;
	localparam logic [7:0] OFF_S_PIN_LEVEL     = 8'h14;
	localparam logic [7:0] OFF_S_DIRECTION     = 8'h18;
	localparam logic [7:0] OFF_S_DRIVE_REDUCE  = 8'h1C;
	localparam logic [7:0] OFF_S_PULL_ENABLE   = 8'h20;
	localparam logic [7:0] OFF_S_PULL_POLARITY = 8'h24;
	localparam logic [7:0] OFF_S_OPEN_DRAIN    = 8'h28;

	// implemented bits
	localparam logic [7:0] P_MASK    = 8'h3F;
	localparam logic [7:0] P_OD_MASK = 8'h35;
	localparam logic [7:0] S_MASK    = 8'hF3;

	// values after reset
	localparam logic [7:0] REG_RESET = 8'h00;

	// pin positions on the second port, and the first port two-wire pins
	localparam int S_SPI_LO = 4;
	localparam int S_TX_PIN = 1;
	localparam int S_RX_PIN = 0;
	localparam int P_TWI_LO = 4;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : port_pins_pkg

// ==== sim/pad_model.sv ====
// pad ring model for the second port: drivers, pulls, outside drive
// assumes registered pad controls from the block on aclk
`timescale 1ns/1ps
module pad_model (
	input  wire logic       aclk,
	input  wire logic [7:0] pad_out,
	input  wire logic [7:0] pad_oe,
	input  wire logic [7:0] pull_en,
	input  wire logic [7:0] pull_down,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pad_level
);
	logic [7:0] flt = 8'h55;
	// undriven pins wander every cycle
	always @(posedge aclk) begin
		flt <= ~flt;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i])
				pad_level[i] = pad_out[i];
			else if (ext_en[i])
				pad_level[i] = ext_val[i];
			else if (pull_en[i])
				pad_level[i] = ~pull_down[i];
			else
				pad_level[i] = flt[i];
		end
	end
endmodule : pad_model

// ==== sim/port_pin_config_tb.sv ====
// self-checking bench for the two-port pin configuration block
// assumes pad_model on the second port pads
`timescale 1ns/1ps
module port_pin_config_tb;
	import port_pins_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, spi_o, spi_e, spi_i;
	logic [1:0]  bresp, rresp, pwm_ch;
	logic [5:0]  p_dir, p_red, p_pen, p_pdn, p_od;
	logic        twi_en, spi_en, tx_en, tx_d, rx_en, rx_d;
	logic [7:0]  s_in, s_out, s_oe, s_red, s_pen, s_pdn, s_od;
	logic [7:0]  ext_en, ext_val;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          cyc = 0;
	logic [7:0]  offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C, 8'h20,
		8'h24, 8'h28, 8'h18};
	logic [7:0]  msk [9] = '{8'h3F, 8'h3F, 8'h3F, 8'h35, 8'hF3, 8'hF3,
		8'hF3, 8'hF3, 8'hF3};

	port_pin_config dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_p_dir(p_dir),
		.twi_enable(twi_en), .pwm_twi_ch_enable(pwm_ch),
		.spi_enable(spi_en), .spi_out(spi_o), .spi_oe(spi_e),
		.sci_tx_enable(tx_en), .sci_tx_data(tx_d), .sci_rx_enable(rx_en),
		.pad_s_in(s_in), .pad_p_reduced(p_red), .pad_p_pull_en(p_pen),
		.pad_p_pull_down(p_pdn), .pad_p_open_drain(p_od),
		.pad_s_out(s_out), .pad_s_oe(s_oe), .pad_s_reduced(s_red),
		.pad_s_pull_en(s_pen), .pad_s_pull_down(s_pdn),
		.pad_s_open_drain(s_od), .spi_in(spi_i), .sci_rx_data(rx_d));

	pad_model pads (.aclk(aclk), .pad_out(s_out), .pad_oe(s_oe),
		.pull_en(s_pen), .pull_down(s_pdn), .ext_en(ext_en),
		.ext_val(ext_val), .pad_level(s_in));

	always #4 aclk = ~aclk;

	// run length guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// ready lines drop after each handshake and each valid falls once its own handshake is seen, so no channel is taken twice a step
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= 32'(d);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk("bresp", 8'(bresp), 8'(r));
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
		input logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		chk("rdata", rdata[7:0] & m, e);
		chk("rdata_top", {7'h00, |rdata[31:8]}, 8'h00);
		chk("rresp", 8'(rresp), 8'(r));
	endtask : rd

	task settle(input int n);
		repeat (n) @(posedge aclk);
	endtask : settle

	task t_regs;
		for (int i = 0; i < 9; i++) begin
			rd(offs[i], 8'h00, 8'hFF, RESP_OKAY);
			wr(offs[i], 8'hFF, RESP_OKAY);
			rd(offs[i], msk[i], 8'hFF, RESP_OKAY);
			wr(offs[i], 8'h00, RESP_OKAY);
		end
		wr(8'h14, 8'hFF, RESP_OKAY);
		wr(8'h2C, 8'hFF, RESP_SLVERR);
		rd(8'h2C, 8'h00, 8'hFF, RESP_SLVERR);
	endtask : t_regs

	task t_port_p;
		p_dir <= 6'h0F;
		wr(8'h00, 8'h3F, RESP_OKAY);
		wr(8'h04, 8'h3F, RESP_OKAY);
		wr(8'h08, 8'h3F, RESP_OKAY);
		wr(8'h0C, 8'h3F, RESP_OKAY);
		settle(2);
		chk("p_red", {2'b00, p_red}, 8'h0F);
		chk("p_pen", {2'b00, p_pen}, 8'h30);
		chk("p_pdn", {2'b00, p_pdn}, 8'h30);
		chk("p_od", {2'b00, p_od}, 8'h05);
		twi_en <= 1'b1;
		settle(2);
		chk("p_od", {2'b00, p_od}, 8'h35);
		pwm_ch <= 2'b10;
		settle(2);
		chk("p_od", {2'b00, p_od}, 8'h15);
		pwm_ch <= 2'b01;
		settle(2);
		chk("p_od", {2'b00, p_od}, 8'h25);
		twi_en <= 1'b0;
	endtask : t_port_p

	task t_port_s;
		wr(8'h18, 8'hF0, RESP_OKAY);
		wr(8'h10, 8'hA1, RESP_OKAY);
		wr(8'h1C, 8'hFF, RESP_OKAY);
		wr(8'h20, 8'hFF, RESP_OKAY);
		wr(8'h24, 8'hFF, RESP_OKAY);
		settle(2);
		chk("s_oe", s_oe, 8'hF0);
		chk("s_out", s_out & s_oe, 8'hA0);
		chk("s_red", s_red, 8'hF0);
		chk("s_pen", s_pen, 8'h03);
		chk("s_pdn", s_pdn, 8'h03);
		wr(8'h28, 8'hF3, RESP_OKAY);
		settle(2);
		chk("s_oe", s_oe, 8'h50);
		chk("s_od", s_od, 8'hF0);
		chk("s_pen", s_pen, 8'hF3);
		settle(3);
		rd(8'h10, 8'hA0, 8'hFF, RESP_OKAY);
		rd(8'h14, 8'hA0, 8'hF3, RESP_OKAY);
		wr(8'h28, 8'h00, RESP_OKAY);
	endtask : t_port_s

	task t_serial;
		wr(8'h18, 8'hF1, RESP_OKAY);
		spi_en <= 1'b1;
		spi_e <= 4'hA;
		spi_o <= 4'h6;
		tx_en <= 1'b1;
		tx_d <= 1'b1;
		rx_en <= 1'b1;
		ext_en <= 8'h01;
		ext_val <= 8'h01;
		settle(2);
		chk("s_oe", s_oe, 8'hA2);
		chk("s_out", s_out & s_oe, 8'h22);
		settle(3);
		chk("spi_in", {4'h0, spi_i}, 8'h02);
		chk("rx", {7'h00, rx_d}, 8'h01);
		spi_en <= 1'b0;
		tx_en <= 1'b0;
		rx_en <= 1'b0;
		ext_en <= 8'h00;
		settle(2);
		chk("s_oe", s_oe, 8'hF1);
	endtask : t_serial

	// reset in mid-run with pins driven and pulls on
	task t_reset;
		aresetn <= 1'b0;
		settle(2);
		chk("s_oe", s_oe, 8'h00);
		chk("s_pen", s_pen, 8'h00);
		aresetn <= 1'b1;
		settle(2);
		rd(8'h18, 8'h00, 8'hFF, RESP_OKAY);
	endtask : t_reset

	task conclude;
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, p_dir, pwm_ch, spi_o, spi_e} = '0;
		{twi_en, spi_en, tx_en, tx_d, rx_en, ext_en, ext_val} = '0;
		wstrb = 4'hF;
		settle(4);
		chk("s_oe", s_oe, 8'h00);
		chk("s_pen", s_pen, 8'h00);
		settle(2);
		aresetn <= 1'b1;
		settle(2);
		t_regs();
		t_port_p();
		t_port_s();
		t_serial();
		t_reset();
		conclude();
	end
endmodule : port_pin_config_tb
